/* File: frame_checksum.sv */
// running sum of frame-data bytes and the checksum byte derived from it
`timescale 1ns/1ps
module frame_checksum (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// byte feed
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] data,
	// result
	output logic [7:0] csum
);

	typedef struct packed {
		logic [7:0] sum;
	} sum_state_s;

	sum_state_s state_ff;
	sum_state_s nxt_state;

	// only the low byte matters, so the sum simply wraps
	always_comb begin
		nxt_state = state_ff;
		if (clear) begin
			nxt_state.sum = 8'h00;
		end else if (add) begin
			nxt_state.sum = state_ff.sum + data;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign csum = rx_frame_pkg::CSUM_BASE - state_ff.sum;

endmodule

/* File: rx_frame_pkg.sv */
// constants, field layouts and carrier types for the receive-indicator framer
package rx_frame_pkg;

	// frame bytes
	localparam logic [7:0] DELIM = 8'h7e;
	localparam logic [7:0] TYPE_EXPLICIT = 8'h91;
	localparam logic [7:0] TYPE_SAMPLE = 8'h92;
	localparam logic [7:0] SAMPLE_SETS = 8'h01;
	localparam logic [7:0] CSUM_BASE = 8'hff;

	// byte offsets within a frame
	localparam logic [4:0] OFS_LEN_HI = 5'h01;
	localparam logic [4:0] OFS_LEN_LO = 5'h02;
	localparam logic [4:0] OFS_TYPE = 5'h03;
	localparam logic [4:0] OFS_ADDR64_LO = 5'h0b;
	localparam logic [4:0] OFS_NET_HI = 5'h0c;
	localparam logic [4:0] OFS_NET_LO = 5'h0d;
	localparam logic [4:0] OFS_SRC_EP = 5'h0e;
	localparam logic [4:0] OFS_DST_EP = 5'h0f;
	localparam logic [4:0] OFS_CLUSTER_HI = 5'h10;
	localparam logic [4:0] OFS_CLUSTER_LO = 5'h11;
	localparam logic [4:0] OFS_PROFILE_HI = 5'h12;
	localparam logic [4:0] OFS_PROFILE_LO = 5'h13;
	localparam logic [4:0] OFS_XOPT = 5'h14;
	localparam logic [4:0] OFS_SOPT = 5'h0e;
	localparam logic [4:0] OFS_SETS = 5'h0f;
	localparam logic [4:0] OFS_DMASK_HI = 5'h10;
	localparam logic [4:0] OFS_DMASK_LO = 5'h11;
	localparam logic [4:0] OFS_AMASK = 5'h12;

	// frame-data bytes before the variable part (offsets 3..20 and 3..18)
	localparam logic [15:0] EXPLICIT_FIXED = 16'h0012;
	localparam logic [15:0] SAMPLE_FIXED = 16'h0010;

	// field values
	localparam logic [63:0] ADDR64_UNKNOWN = 64'hffff_ffff_ffff_ffff;
	localparam logic [7:0] XOPT_USED = 8'h23;
	localparam logic [7:0] SOPT_USED = 8'h03;
	localparam logic [15:0] DMASK_USED = 16'h1cff;
	localparam logic [7:0] AMASK_USED = 8'h8f;
	localparam int ANALOG_INPUTS = 4;
	localparam int TAIL_BYTES = 10;

	// register port
	localparam int REG_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CNT_EXPLICIT = 8'h08;
	localparam logic [7:0] REG_CNT_SAMPLE = 8'h0c;
	localparam logic [7:0] REG_CNT_DROP = 8'h10;
	localparam int CTRL_EXPLICIT_BIT = 0;
	localparam int CTRL_API_BIT = 1;
	localparam logic RST_EXPLICIT = 1'b0;
	localparam logic RST_API = 1'b1;

	// header of a received radio packet
	typedef struct packed {
		logic addr64Known;
		logic [63:0] addr64;
		logic [15:0] net16;
		logic [7:0] srcEp;
		logic [7:0] dstEp;
		logic [15:0] cluster;
		logic [15:0] profile;
		logic [7:0] options;
		logic [7:0] payLen;
	} pkt_hdr_s;

	// one remote i/o sample set
	typedef struct packed {
		logic [63:0] addr64;
		logic [15:0] net16;
		logic [7:0] options;
		logic [15:0] dMask;
		logic [7:0] aMask;
		logic [15:0] dLevels;
		logic [3:0][15:0] analog;
	} smp_req_s;

	// sample bytes that follow the analog mask
	typedef struct packed {
		logic [TAIL_BYTES-1:0][7:0] bytes;
		logic [3:0] count;
	} tail_s;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_HEAD = 3'b001,
		PH_PAY = 3'b010,
		PH_TAIL = 3'b011,
		PH_CSUM = 3'b100,
		PH_DRAIN = 3'b101
	} phase_e;

endpackage

/* File: rx_host_sink.sv */
// host-side model that reads frame bytes, promptly or with stalls
`timescale 1ns/1ps
module rx_host_sink (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// pacing: high stalls three cycles of four
	input wire logic slow,
	// serial stream
	input wire logic txValid,
	input wire logic [7:0] txData,
	output logic txReady,
	// bytes as the host reads them
	output logic seen,
	output logic [7:0] seenByte
);
	logic [1:0] tick_ff;
	logic [15:0] ofs_ff;
	logic [15:0] len_ff;
	logic sample_ff;

	// acceptance and pacing
	assign txReady = !slow || tick_ff == 2'b00;
	assign seen = txValid && txReady;
	// only ack and broadcast bits are read
	assign seenByte = (sample_ff && ofs_ff == 16'h000e) ?
		(txData & 8'h03) : txData;

	// offset within the frame, from the length field
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tick_ff <= 2'b00;
			ofs_ff <= 16'h0000;
			len_ff <= 16'h0000;
			sample_ff <= 1'b0;
		end else begin
			tick_ff <= tick_ff + 2'b01;
			if (seen) begin
				ofs_ff <= (ofs_ff > 16'h0003 && ofs_ff == len_ff + 16'h0003) ?
					16'h0000 : ofs_ff + 16'h0001;
				if (ofs_ff == 16'h0001)
					len_ff[15:8] <= txData;
				if (ofs_ff == 16'h0002)
					len_ff[7:0] <= txData;
				if (ofs_ff == 16'h0003)
					sample_ff <= txData == 8'h92;
			end
		end
	end
endmodule

/* File: rx_indicator_frame_builder.sv */
// serial frame builder for explicit receive and i/o sample indicators
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module rx_indicator_frame_builder (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// register port
	input wire logic [rx_frame_pkg::REG_AW-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// received radio packet header
	input wire logic pktValid,
	input wire rx_frame_pkg::pkt_hdr_s pktHdr,
	output logic pktReady,
	// received payload bytes
	input wire logic payValid,
	input wire logic [7:0] payData,
	output logic payReady,
	// received remote sample set
	input wire logic smpValid,
	input wire rx_frame_pkg::smp_req_s smpReq,
	output logic smpReady,
	// serial api byte stream
	output logic txValid,
	output logic [7:0] txData,
	input wire logic txReady
);

	typedef struct packed {
		rx_frame_pkg::phase_e phase;
		logic kindSample;
		logic [4:0] idx;
		logic [15:0] len;
		logic [7:0] remain;
		logic [3:0] tailPos;
		rx_frame_pkg::pkt_hdr_s hdr;
		logic [15:0] dMask;
		logic [7:0] aMask;
		rx_frame_pkg::tail_s tail;
		logic txValid;
		logic [7:0] txData;
		logic payReady;
		logic pktReady;
		logic smpReady;
		logic [31:0] regRdData;
		logic rx_indicator_format_option;
		logic apiFramed;
		logic [15:0] cntExplicit;
		logic [15:0] cntSample;
		logic [15:0] cntDrop;
	} top_s;

	top_s state_ff, nxt_state;

	rx_frame_pkg::tail_s smpTail;
	logic csumClear, csumAdd;
	logic [7:0] csumByte;

	// sample tail is built from the request while it waits to be taken
	sample_tail_packer u_packer (
		.dMask(smpReq.dMask & rx_frame_pkg::DMASK_USED),
		.aMask(smpReq.aMask & rx_frame_pkg::AMASK_USED),
		.dLevels(smpReq.dLevels),
		.analog(smpReq.analog),
		.tail(smpTail)
	);
	frame_checksum u_csum (
		.clock(clock),
		.arst_n(arst_n),
		.clear(csumClear),
		.add(csumAdd),
		.data(nxt_state.txData),
		.csum(csumByte)
	);

	// byte at a fixed offset of the frame head
	function automatic logic [7:0] headByte(
		input logic [4:0] idx,
		input logic kindSample,
		input logic [15:0] len,
		input rx_frame_pkg::pkt_hdr_s hdr,
		input logic [15:0] dMask,
		input logic [7:0] aMask
	);
		logic [7:0] b;
		b = 8'h00;
		if (idx == 5'h00) begin
			b = rx_frame_pkg::DELIM;
		end else if (idx == rx_frame_pkg::OFS_LEN_HI) begin
			b = len[15:8];
		end else if (idx == rx_frame_pkg::OFS_LEN_LO) begin
			b = len[7:0];
		end else if (idx == rx_frame_pkg::OFS_TYPE) begin
			b = kindSample ? rx_frame_pkg::TYPE_SAMPLE
				: rx_frame_pkg::TYPE_EXPLICIT;
		end else if (idx <= rx_frame_pkg::OFS_ADDR64_LO) begin
			b = hdr.addr64[8 * (rx_frame_pkg::OFS_ADDR64_LO - idx) +: 8];
		end else if (idx == rx_frame_pkg::OFS_NET_HI) begin
			b = hdr.net16[15:8];
		end else if (idx == rx_frame_pkg::OFS_NET_LO) begin
			b = hdr.net16[7:0];
		end else if (kindSample) begin
			case (idx)
				rx_frame_pkg::OFS_SOPT: b = hdr.options
					& rx_frame_pkg::SOPT_USED;
				rx_frame_pkg::OFS_SETS: b = rx_frame_pkg::SAMPLE_SETS;
				rx_frame_pkg::OFS_DMASK_HI: b = dMask[15:8];
				rx_frame_pkg::OFS_DMASK_LO: b = dMask[7:0];
				rx_frame_pkg::OFS_AMASK: b = aMask;
				default: b = 8'h00;
			endcase
		end else begin
			case (idx)
				rx_frame_pkg::OFS_SRC_EP: b = hdr.srcEp;
				rx_frame_pkg::OFS_DST_EP: b = hdr.dstEp;
				rx_frame_pkg::OFS_CLUSTER_HI: b = hdr.cluster[15:8];
				rx_frame_pkg::OFS_CLUSTER_LO: b = hdr.cluster[7:0];
				rx_frame_pkg::OFS_PROFILE_HI: b = hdr.profile[15:8];
				rx_frame_pkg::OFS_PROFILE_LO: b = hdr.profile[7:0];
				rx_frame_pkg::OFS_XOPT: b = hdr.options
					& rx_frame_pkg::XOPT_USED;
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	// register read value
	function automatic logic [31:0] regValue(
		input logic [rx_frame_pkg::REG_AW-1:0] addr,
		input top_s s
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (addr)
			rx_frame_pkg::REG_CTRL: begin
				v[rx_frame_pkg::CTRL_EXPLICIT_BIT] =
					s.rx_indicator_format_option;
				v[rx_frame_pkg::CTRL_API_BIT] = s.apiFramed;
			end
			rx_frame_pkg::REG_STATUS: begin
				v[0] = (s.phase != rx_frame_pkg::PH_IDLE) || s.txValid;
				v[3:1] = s.phase;
			end
			rx_frame_pkg::REG_CNT_EXPLICIT: v[15:0] = s.cntExplicit;
			rx_frame_pkg::REG_CNT_SAMPLE: v[15:0] = s.cntSample;
			rx_frame_pkg::REG_CNT_DROP: v[15:0] = s.cntDrop;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	logic slotFree, payTake, pktTake, smpTake;
	// the output byte slot may be refilled once the host has taken it
	assign slotFree = !state_ff.txValid || txReady;
	assign payTake = payValid && state_ff.payReady;
	assign pktTake = state_ff.phase == rx_frame_pkg::PH_IDLE
		&& pktValid && state_ff.pktReady;
	assign smpTake = state_ff.phase == rx_frame_pkg::PH_IDLE
		&& smpValid && state_ff.smpReady;
	// next state: register port, byte slot and framing phase
	always_comb begin
		nxt_state = state_ff;
		csumClear = 1'b0;
		csumAdd = 1'b0;
		// register port: data valid only in the cycle after the read
		nxt_state.regRdData = regRd ? regValue(regAddr, state_ff)
			: 32'h0000_0000;
		if (regWr && regAddr == rx_frame_pkg::REG_CTRL) begin
			nxt_state.rx_indicator_format_option =
				regWrData[rx_frame_pkg::CTRL_EXPLICIT_BIT];
			nxt_state.apiFramed = regWrData[rx_frame_pkg::CTRL_API_BIT];
		end
		// the host took the byte on offer
		if (state_ff.txValid && txReady) begin
			nxt_state.txValid = 1'b0;
		end
		case (state_ff.phase)
			rx_frame_pkg::PH_IDLE: begin
				if (pktTake) begin
					nxt_state.hdr = pktHdr;
					nxt_state.remain = pktHdr.payLen;
					nxt_state.idx = 5'h00;
					nxt_state.kindSample = 1'b0;
					nxt_state.len = rx_frame_pkg::EXPLICIT_FIXED
						+ {8'h00, pktHdr.payLen};
					if (!pktHdr.addr64Known) begin
						nxt_state.hdr.addr64 = rx_frame_pkg::ADDR64_UNKNOWN;
					end
					// only explicit mode frames a packet
					if (state_ff.rx_indicator_format_option) begin
						nxt_state.phase = rx_frame_pkg::PH_HEAD;
						csumClear = 1'b1;
					end else begin
						// standard receive frames are not built here
						nxt_state.cntDrop = state_ff.cntDrop + 16'h0001;
						if (pktHdr.payLen != 8'h00) begin
							nxt_state.phase = rx_frame_pkg::PH_DRAIN;
						end
					end
				end else if (smpTake) begin
					nxt_state.hdr = '0;
					nxt_state.hdr.addr64 = smpReq.addr64;
					nxt_state.hdr.net16 = smpReq.net16;
					nxt_state.hdr.options = smpReq.options;
					nxt_state.dMask = smpReq.dMask & rx_frame_pkg::DMASK_USED;
					nxt_state.aMask = smpReq.aMask & rx_frame_pkg::AMASK_USED;
					nxt_state.tail = smpTail;
					nxt_state.tailPos = 4'h0;
					nxt_state.idx = 5'h00;
					nxt_state.kindSample = 1'b1;
					nxt_state.len = rx_frame_pkg::SAMPLE_FIXED
						+ {12'h000, smpTail.count};
					// and only in framed api mode
					if (!state_ff.rx_indicator_format_option
						&& state_ff.apiFramed) begin
						nxt_state.phase = rx_frame_pkg::PH_HEAD;
						csumClear = 1'b1;
					end else begin
						nxt_state.cntDrop = state_ff.cntDrop + 16'h0001;
					end
				end
			end
			rx_frame_pkg::PH_HEAD: begin
				// one byte per free slot, offsets ascend
				if (slotFree) begin
					nxt_state.txData = headByte(state_ff.idx,
						state_ff.kindSample, state_ff.len, state_ff.hdr,
						state_ff.dMask, state_ff.aMask);
					nxt_state.txValid = 1'b1;
					nxt_state.idx = state_ff.idx + 5'h01;
					csumAdd = state_ff.idx >= rx_frame_pkg::OFS_TYPE;
					if (state_ff.kindSample
						&& state_ff.idx == rx_frame_pkg::OFS_AMASK) begin
						nxt_state.phase = (state_ff.tail.count != 4'h0)
							? rx_frame_pkg::PH_TAIL : rx_frame_pkg::PH_CSUM;
					end else if (!state_ff.kindSample
						&& state_ff.idx == rx_frame_pkg::OFS_XOPT) begin
						nxt_state.phase = (state_ff.remain != 8'h00)
							? rx_frame_pkg::PH_PAY : rx_frame_pkg::PH_CSUM;
					end
				end
			end
			rx_frame_pkg::PH_PAY: begin
				// payload passes through from offset 21
				if (payTake) begin
					nxt_state.txData = payData;
					nxt_state.txValid = 1'b1;
					nxt_state.remain = state_ff.remain - 8'h01;
					csumAdd = 1'b1;
					if (state_ff.remain == 8'h01) begin
						nxt_state.phase = rx_frame_pkg::PH_CSUM;
					end
				end
			end
			rx_frame_pkg::PH_TAIL: begin
				if (slotFree) begin
					nxt_state.txData = state_ff.tail.bytes[state_ff.tailPos];
					nxt_state.txValid = 1'b1;
					nxt_state.tailPos = state_ff.tailPos + 4'h1;
					csumAdd = 1'b1;
					if (state_ff.tailPos + 4'h1 == state_ff.tail.count) begin
						nxt_state.phase = rx_frame_pkg::PH_CSUM;
					end
				end
			end
			rx_frame_pkg::PH_CSUM: begin
				if (slotFree) begin
					nxt_state.txData = csumByte;
					nxt_state.txValid = 1'b1;
					nxt_state.phase = rx_frame_pkg::PH_IDLE;
					if (state_ff.kindSample) begin
						nxt_state.cntSample = state_ff.cntSample + 16'h0001;
					end else begin
						nxt_state.cntExplicit = state_ff.cntExplicit
							+ 16'h0001;
					end
				end
			end
			rx_frame_pkg::PH_DRAIN: begin
				// dropped payload is consumed so the source never jams
				if (payTake) begin
					nxt_state.remain = state_ff.remain - 8'h01;
					if (state_ff.remain == 8'h01) begin
						nxt_state.phase = rx_frame_pkg::PH_IDLE;
					end
				end
			end
			default: begin
				nxt_state.phase = rx_frame_pkg::PH_IDLE;
			end
		endcase
		// payload ready while the slot stays empty, at half rate; ready every cycle while draining
		nxt_state.payReady = (nxt_state.phase == rx_frame_pkg::PH_PAY
			&& !nxt_state.txValid)
			|| nxt_state.phase == rx_frame_pkg::PH_DRAIN;
		// requests alternate so that at most one ready is ever high
		if (nxt_state.phase == rx_frame_pkg::PH_IDLE && !pktTake
			&& !smpTake) begin
			nxt_state.pktReady = !state_ff.pktReady;
			nxt_state.smpReady = state_ff.pktReady;
		end else begin
			nxt_state.pktReady = 1'b0;
			nxt_state.smpReady = 1'b0;
		end
	end
	// state register; idle phase is code zero, control bits have own reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '0;
			state_ff.rx_indicator_format_option <=
				rx_frame_pkg::RST_EXPLICIT;
			state_ff.apiFramed <= rx_frame_pkg::RST_API;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign regRdData = state_ff.regRdData;
	assign pktReady = state_ff.pktReady;
	assign smpReady = state_ff.smpReady;
	assign payReady = state_ff.payReady;
	assign txValid = state_ff.txValid;
	assign txData = state_ff.txData;
endmodule

/* File: rx_indicator_frame_builder_chk.sv */
// port-level checks for the receive-indicator frame builder
`timescale 1ns/1ps
module rx_indicator_frame_builder_chk (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// control writes
	input wire logic [rx_frame_pkg::REG_AW-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	// requests
	input wire logic pktValid,
	input wire logic pktReady,
	input wire logic smpValid,
	input wire logic smpReady,
	// serial stream
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txReady
);
	logic [15:0] idx_ff;
	logic [15:0] len_ff;
	logic [7:0] sum_ff;
	logic explicit_ff;
	logic api_ff;
	logic acc;
	logic last;
	logic isSample;

	// byte accepted, and whether it is the checksum of the frame
	assign acc = txValid && txReady;
	assign last = idx_ff > 16'h0003 && idx_ff == len_ff + 16'h0003;
	assign isSample = !explicit_ff;

	// mode mirror and frame position; the length is only known after byte 2
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			idx_ff <= 16'h0000;
			len_ff <= 16'h0000;
			sum_ff <= 8'h00;
			explicit_ff <= rx_frame_pkg::RST_EXPLICIT;
			api_ff <= rx_frame_pkg::RST_API;
		end else begin
			if (regWr && regAddr == rx_frame_pkg::REG_CTRL) begin
				explicit_ff <= regWrData[rx_frame_pkg::CTRL_EXPLICIT_BIT];
				api_ff <= regWrData[rx_frame_pkg::CTRL_API_BIT];
			end
			if (acc) begin
				idx_ff <= last ? 16'h0000 : idx_ff + 16'h0001;
				sum_ff <= (idx_ff < 16'h0003 || last) ? 8'h00 : sum_ff + txData;
				if (idx_ff == 16'h0001)
					len_ff[15:8] <= txData;
				if (idx_ff == 16'h0002)
					len_ff[7:0] <= txData;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// request taken that must open a frame, or be dropped silently
	sequence s_take;
		!txValid && ((pktValid && pktReady && explicit_ff)
			|| (smpValid && smpReady && api_ff && !explicit_ff));
	endsequence
	sequence s_drop;
		!txValid && ((pktValid && pktReady && !explicit_ff)
			|| (smpValid && smpReady && (explicit_ff || !api_ff)));
	endsequence
	sequence s_head;
		txValid && txData == rx_frame_pkg::DELIM;
	endsequence

	property p_hold;
		txValid && !txReady |=> txValid && $stable(txData);
	endproperty
	property p_start;
		s_take |=> ##1 s_head;
	endproperty
	property p_drop;
		s_drop |=> !txValid [*2];
	endproperty
	property p_delim;
		acc && idx_ff == 16'h0000 |-> txData == rx_frame_pkg::DELIM;
	endproperty
	property p_type;
		acc && idx_ff == 16'h0003 |-> txData == (explicit_ff ?
			rx_frame_pkg::TYPE_EXPLICIT : rx_frame_pkg::TYPE_SAMPLE);
	endproperty
	property p_opt;
		acc && isSample && idx_ff == 16'h000e |-> (txData & 8'hfc) == 8'h00;
	endproperty
	property p_sets;
		acc && isSample && idx_ff == 16'h000f
			|-> txData == rx_frame_pkg::SAMPLE_SETS;
	endproperty
	property p_csum;
		acc && last |-> txData == rx_frame_pkg::CSUM_BASE - sum_ff;
	endproperty
	property p_quiet;
		txValid && (idx_ff < 16'h0003 || idx_ff < len_ff + 16'h0003)
			|-> !pktReady && !smpReady;
	endproperty

	a_hold: assert property (p_hold)
		else $error("stream byte changed before acceptance");
	a_start: assert property (p_start)
		else $error("accepted request did not open a frame");
	a_drop: assert property (p_drop)
		else $error("dropped request produced output");
	a_delim: assert property (p_delim)
		else $error("frame does not start with delimiter");
	a_type: assert property (p_type)
		else $error("frame type byte wrong for mode");
	a_opt: assert property (p_opt)
		else $error("sample option byte has stray bits");
	a_sets: assert property (p_sets)
		else $error("sample set count is not one");
	a_csum: assert property (p_csum)
		else $error("checksum byte wrong");
	a_quiet: assert property (p_quiet)
		else $error("request offered in mid frame");
endmodule

bind rx_indicator_frame_builder rx_indicator_frame_builder_chk
	rx_indicator_frame_builder_chk_i (
	.clock(clock), .arst_n(arst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .pktValid(pktValid),
	.pktReady(pktReady), .smpValid(smpValid), .smpReady(smpReady),
	.txValid(txValid), .txData(txData), .txReady(txReady));

/* File: rx_indicator_frame_builder_tb_top.sv */
// self-checking bench for the receive-indicator frame builder
`timescale 1ns/1ps
module rx_indicator_frame_builder_tb_top;
	logic clock, arst_n, regWr, regRd, pktValid, pktReady, payValid, payReady;
	logic smpValid, smpReady, txValid, txReady, slow, seen;
	logic [rx_frame_pkg::REG_AW-1:0] regAddr;
	logic [31:0] regWrData, regRdData;
	logic [7:0] payData, txData, seenByte;
	rx_frame_pkg::pkt_hdr_s pktHdr, h;
	rx_frame_pkg::smp_req_s smpReq, s;
	logic [7:0] expQ[$], body[$];
	logic [7:0] opts[4] = '{8'h01, 8'hc2, 8'h20, 8'h23};
	logic [15:0] lfsr;
	int errors, check_count, nExp, nSmp, nDrop;

	rx_indicator_frame_builder rx_indicator_frame_builder_i (.clock(clock),
		.arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.pktValid(pktValid), .pktHdr(pktHdr), .pktReady(pktReady),
		.payValid(payValid), .payData(payData), .payReady(payReady),
		.smpValid(smpValid), .smpReq(smpReq), .smpReady(smpReady),
		.txValid(txValid), .txData(txData), .txReady(txReady));
	rx_host_sink rx_host_sink_i (.clock(clock), .arst_n(arst_n), .slow(slow),
		.txValid(txValid), .txData(txData), .txReady(txReady), .seen(seen),
		.seenByte(seenByte));

	// clock of 8 ns
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	task automatic fail(input string m);
		$display("wrong value at %0t: %s", $time, m);
		errors++;
	endtask
	task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
			fail($sformatf("frame byte %h, want %h", got, exp));
	endtask
	task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
			fail($sformatf("register %h, want %h", got, exp));
	endtask
	task automatic results();
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// each byte the host reads is matched against the oldest expectation
	always @(posedge clock) begin
		if (seen === 1'b1) begin
			if (expQ.size() == 0)
				fail("unexpected frame byte");
			else
				checkByte(seenByte, expQ.pop_front());
		end
	end

	// register port: one-cycle strobes, read data in the next cycle only
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1;
		checkReg(regRdData, exp);
	endtask

	// bounded waits on a ready flag or on the expected stream running dry
	task automatic waitTake(input int w);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while ((w == 0 ? pktReady : w == 1 ? payReady : smpReady) !== 1'b1
			&& n < 300);
		if (n >= 300) begin
			fail("request never taken");
			results();
		end
	endtask
	task automatic waitIdle();
		int n;
		n = 0;
		while (expQ.size() != 0 && n < 5000) begin
			@(posedge clock);
			n++;
		end
		if (n >= 5000) begin
			fail("frame stalled");
			results();
		end
		repeat (4) @(posedge clock);
	endtask

	// frame expectations: body bytes wrapped with delimiter, length, checksum
	task automatic push16(input logic [15:0] v);
		body.push_back(v[15:8]);
		body.push_back(v[7:0]);
	endtask
	task automatic push64(input logic [63:0] v);
		for (int i = 3; i >= 0; i--)
			push16(v[i*16 +: 16]);
	endtask
	task automatic pushFrame();
		logic [7:0] sum;
		logic [15:0] len;
		sum = 8'h00;
		len = 16'(body.size());
		expQ.push_back(rx_frame_pkg::DELIM);
		expQ.push_back(len[15:8]);
		expQ.push_back(len[7:0]);
		foreach (body[i]) begin
			sum = sum + body[i];
			expQ.push_back(body[i]);
		end
		expQ.push_back(rx_frame_pkg::CSUM_BASE - sum);
		body.delete();
	endtask

	task automatic sendSample(input rx_frame_pkg::smp_req_s r, input logic f);
		if (f) begin
			body.push_back(rx_frame_pkg::TYPE_SAMPLE);
			push64(r.addr64);
			push16(r.net16);
			body.push_back(r.options & rx_frame_pkg::SOPT_USED);
			body.push_back(rx_frame_pkg::SAMPLE_SETS);
			push16(r.dMask);
			body.push_back(r.aMask);
			if (r.dMask != 16'h0000)
				push16(r.dLevels & r.dMask);
			for (int i = 0; i < 4; i++)
				if (r.aMask[i])
					push16(r.analog[i]);
			pushFrame();
			nSmp++;
		end else
			nDrop++;
		@(posedge clock);
		smpReq <= r;
		smpValid <= 1'b1;
		waitTake(2);
		smpValid <= 1'b0;
	endtask

	task automatic sendPkt(input rx_frame_pkg::pkt_hdr_s p, input logic f);
		logic [7:0] pay[$];
		for (int i = 0; i < p.payLen; i++)
			pay.push_back(8'(rnd()));
		if (f) begin
			body.push_back(rx_frame_pkg::TYPE_EXPLICIT);
			push64(p.addr64Known ? p.addr64 : rx_frame_pkg::ADDR64_UNKNOWN);
			push16(p.net16);
			body.push_back(p.srcEp);
			body.push_back(p.dstEp);
			push16(p.cluster);
			push16(p.profile);
			body.push_back(p.options & rx_frame_pkg::XOPT_USED);
			body = {body, pay};
			pushFrame();
			nExp++;
		end else
			nDrop++;
		@(posedge clock);
		pktHdr <= p;
		pktValid <= 1'b1;
		waitTake(0);
		pktValid <= 1'b0;
		foreach (pay[i]) begin
			payData <= pay[i];
			payValid <= 1'b1;
			waitTake(1);
		end
		payValid <= 1'b0;
	endtask

	// main sequence
	initial begin
		{arst_n, regWr, regRd, pktValid, payValid, smpValid, slow} = 7'h00;
		{regAddr, regWrData, payData} = 48'h0;
		pktHdr = '0;
		smpReq = '0;
		lfsr = 16'h002d;
		{errors, check_count, nExp, nSmp, nDrop} = '0;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		regWrite(8'h20, 32'h0000_0001);
		regRead(rx_frame_pkg::REG_CTRL, 32'h0000_0002);
		regRead(8'h20, 32'h0000_0000);
		regRead(rx_frame_pkg::REG_STATUS, 32'h0000_0000);
		// standard mode samples: empty masks, full masks, then random
		for (int i = 0; i < 6; i++) begin
			for (int k = 0; k < 12; k++)
				s = {s[175:0], rnd()};
			s.dMask = i == 0 ? 16'h0000 : i == 1 ? rx_frame_pkg::DMASK_USED
				: s.dMask & rx_frame_pkg::DMASK_USED;
			s.aMask = i == 0 ? 8'h00 : i == 1 ? rx_frame_pkg::AMASK_USED
				: s.aMask & rx_frame_pkg::AMASK_USED;
			slow <= i[0];
			sendSample(s, 1'b1);
		end
		for (int k = 0; k < 10; k++)
			h = {h[128:0], rnd()};
		h.payLen = 8'h03;
		sendPkt(h, 1'b0);
		waitIdle();
		regWrite(rx_frame_pkg::REG_CTRL, 32'h0000_0000);
		sendSample(s, 1'b0);
		waitIdle();
		regWrite(rx_frame_pkg::REG_CTRL, 32'h0000_0003);
		// explicit frames: unknown address, empty payload, slow host
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 10; k++)
				h = {h[128:0], rnd()};
			h.addr64Known = i != 0;
			h.options = opts[i];
			h.payLen = i == 1 ? 8'h00 : h.payLen & 8'h1f;
			slow <= i == 2;
			sendPkt(h, 1'b1);
		end
		sendSample(s, 1'b0);
		waitIdle();
		regRead(rx_frame_pkg::REG_CNT_EXPLICIT, 32'(nExp));
		regRead(rx_frame_pkg::REG_CNT_SAMPLE, 32'(nSmp));
		regRead(rx_frame_pkg::REG_CNT_DROP, 32'(nDrop));
		regRead(rx_frame_pkg::REG_CTRL, 32'h0000_0003);
		results();
	end
endmodule

/* File: sample_tail_packer.sv */
// packs digital levels and enabled analog results into the sample tail
`timescale 1ns/1ps
module sample_tail_packer (
	// sample set
	input wire logic [15:0] dMask,
	input wire logic [7:0] aMask,
	input wire logic [15:0] dLevels,
	input wire logic [3:0][15:0] analog,
	// packed bytes
	output rx_frame_pkg::tail_s tail
);

	// digital pair only when some line is enabled, then analog in order
	always_comb begin
		logic [15:0] levels;
		logic [3:0] n;
		levels = 16'h0000;
		n = 4'h0;
		tail = '0;
		if (dMask != 16'h0000) begin
			levels = dLevels & dMask;
			tail.bytes[0] = levels[15:8];
			tail.bytes[1] = levels[7:0];
			n = 4'h2;
		end
		for (int i = 0; i < rx_frame_pkg::ANALOG_INPUTS; i++) begin
			if (aMask[i]) begin
				tail.bytes[n] = analog[i][15:8];
				tail.bytes[n + 4'h1] = analog[i][7:0];
				n = n + 4'h2;
			end
		end
		tail.count = n;
	end

endmodule
